// [hw/ccf_alu.sv]
// alu flag evaluation for the condition flag block
// assumes operands and current carry/half carry from the flag register
`timescale 1ns/1ps
`default_nettype none
module ccf_alu (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic c_in,
   input wire logic h_in,
   input wire ccf_pkg::ccf_op_type op,
   output ccf_pkg::ccf_alu_type out
);
   import ccf_pkg::*;
   logic [8:0] sum; // nine bit sum/difference
   logic [4:0] low; // low nibble sum
   logic [7:0] corr; // decimal correction
   logic cin; // effective carry in
   // ----------------------------------------------------------------
   // combinational flag evaluation
   // ----------------------------------------------------------------
   always_comb begin
      out = '0;
      sum = '0;
      low = '0;
      corr = '0;
      cin = ((op == CCF_OP_ADC) || (op == CCF_OP_SBC)) ? c_in : 1'b0;
      case (op)
         CCF_OP_ADD, CCF_OP_ADC: begin
            sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            out.res = sum[7:0];
            out.h = low[4];
            out.h_wr = 1'b1;
            out.c = sum[8];
            out.c_wr = 1'b1;
            out.v = (a[7] == b[7]) && (sum[7] != a[7]);
            out.v_wr = 1'b1;
         end
         CCF_OP_SUB, CCF_OP_SBC: begin
            sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            out.res = sum[7:0];
            out.c = sum[8];
            out.c_wr = 1'b1;
            out.v = (a[7] != b[7]) && (sum[7] != a[7]);
            out.v_wr = 1'b1;
         end
         CCF_OP_AND: begin
            out.res = a & b;
            out.v_wr = 1'b1;
         end
         CCF_OP_MOV: begin
            out.res = a;
            out.v_wr = 1'b1;
         end
         CCF_OP_LSL: begin
            out.res = {a[6:0], 1'b0};
            out.c = a[7];
            out.c_wr = 1'b1;
            out.v = a[7] ^ a[6];
            out.v_wr = 1'b1;
         end
         CCF_OP_ROR: begin
            out.res = {c_in, a[7:1]};
            out.c = a[0];
            out.c_wr = 1'b1;
            out.v = c_in ^ a[0];
            out.v_wr = 1'b1;
         end
         CCF_OP_BTB: begin
            out.res = a;
            out.c = a[b[2:0]];
            out.c_wr = 1'b1;
         end
         CCF_OP_DAA: begin
            // correction from current half carry and carry
            if (h_in || (a[3:0] > 4'h9)) begin
               corr[3:0] = 4'h6;
            end
            if (c_in || (a > 8'h99)) begin
               corr[7:4] = 4'h6;
            end
            sum = {1'b0, a} + {1'b0, corr};
            out.res = sum[7:0];
            out.c = c_in || (a > 8'h99);
            out.c_wr = 1'b1;
         end
         default: begin
            out = '0;
         end
      endcase
   end
endmodule // ccf_alu
`default_nettype wire

// [hw/ccf_pkg.sv]
// package for the condition flag block: register layout, offsets, codes
// assumes an apb slave wrapper and a core sequencer driving op strobes
package ccf_pkg;
   // ----------------------------------------------------------------
   // flag bit positions
   // ----------------------------------------------------------------
   localparam int unsigned CCF_BIT_V = 7; // overflow
   localparam int unsigned CCF_BIT_ONE6 = 6; // always one
   localparam int unsigned CCF_BIT_ONE5 = 5; // always one
   localparam int unsigned CCF_BIT_H = 4; // half carry
   localparam int unsigned CCF_BIT_I = 3; // interrupt mask
   localparam int unsigned CCF_BIT_N = 2; // negative
   localparam int unsigned CCF_BIT_Z = 1; // zero
   localparam int unsigned CCF_BIT_C = 0; // carry
   localparam logic [7:0] CCF_ONES_MASK = 8'h60; // bits 6 and 5
   localparam logic [7:0] CCF_FLAGS_RESET = 8'h68; // mask set, ones
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] CCF_OFF_FLAGS = 12'h000; // condition_flags_reg
   localparam logic [11:0] CCF_OFF_OPA = 12'h004; // operand a
   localparam logic [11:0] CCF_OFF_OPB = 12'h008; // operand b
   localparam logic [11:0] CCF_OFF_CMD = 12'h00C; // op command, write
   localparam logic [11:0] CCF_OFF_RES = 12'h010; // last result
   localparam logic [11:0] CCF_OFF_IRQ = 12'h014; // pending requests
   localparam logic [11:0] CCF_OFF_STAT = 12'h018; // break/vector status
   localparam logic [11:0] CCF_OFF_STACK = 12'h01C; // stacked flag image
   // ----------------------------------------------------------------
   // vectors
   // ----------------------------------------------------------------
   localparam logic [15:0] CCF_VEC_TRAP = 16'hFFFC; // soft trap vector
   localparam logic [15:0] CCF_VEC_TRAP_MON = 16'hFEFC; // monitor mode
   localparam logic [15:0] CCF_VEC_BASE = 16'hFFD8; // lowest irq vector
   localparam logic [15:0] CCF_VEC_STEP = 16'h0002; // bytes per vector
   localparam int unsigned CCF_NREQ = 17; // maskable request lines
   // ----------------------------------------------------------------
   // operation codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CCF_OP_ADD = 4'h0, // add
      CCF_OP_ADC = 4'h1, // add with carry
      CCF_OP_SUB = 4'h2, // subtract
      CCF_OP_SBC = 4'h3, // subtract with borrow
      CCF_OP_AND = 4'h4, // logic and
      CCF_OP_MOV = 4'h5, // data move
      CCF_OP_LSL = 4'h6, // shift left
      CCF_OP_ROR = 4'h7, // rotate right through carry
      CCF_OP_DAA = 4'h8, // decimal_adjust_op
      CCF_OP_CLI = 4'h9, // mask_clear_op
      CCF_OP_SEI = 4'hA, // set mask
      CCF_OP_SWI = 4'hB, // soft_trap_op
      CCF_OP_RTI = 4'hC, // return_from_handler
      CCF_OP_BTB = 4'hD // bit test and branch (carry = bit)
   } ccf_op_type;
   // alu result carrier
   typedef struct packed {
      logic [7:0] res; // result byte
      logic v; // overflow
      logic h; // half carry
      logic h_wr; // h is updated
      logic v_wr; // v is updated
      logic c; // carry
      logic c_wr; // c is updated
   } ccf_alu_type;
   // interrupt sequencer states, one hot
   typedef enum logic [3:0] {
      CCF_ST_RUN = 4'b0001, // normal execution
      CCF_ST_PUSH = 4'b0010, // registers pushed
      CCF_ST_MASK = 4'b0100, // mask set
      CCF_ST_FETCH = 4'b1000 // vector fetched
   } ccf_state_type;
endpackage

// [hw/ccf_top.sv]
// condition flag register, interrupt mask sequencing and break entry
// assumes an apb master and a core sequencer/irq arbiter around it
//
// How it works
// - eight bit flags, bits six five read one
// - overflow set on signed overflow, else cleared; kept by decimal adjust and bit test
// - half carry from bit three on add
// - decimal adjust uses half carry and carry
// - mask set blocks maskable interrupts
// - mask set after push, before vector fetch
// - high index byte never stacked automatically
// - highest priority pending request served first
// - return restores mask from stacked flags
// - reset sets mask; only clear op or return clears
// - negative follows result bit seven
// - zero set when result is zero
// - carry from add, borrow, shift, bit test
// - break runs soft trap, vector by mode
// - return ends break if request released
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ccf_top #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ccf_pkg::CCF_NREQ-1:0] irq_req,
   input wire logic brk_req,
   input wire logic brk_en,
   input wire logic monitor_mode,
   output logic [7:0] flags_out,
   output logic irq_mask_out,
   output logic [15:0] vec_addr,
   output logic vec_fetch,
   output logic in_break
);
   import ccf_pkg::*;

   // refuse an address width that cannot reach the whole map
   if (ADDR_W < 5) begin : g_addr_chk
      $error("ccf_top: ADDR_W too small for register map");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] flags_q; // condition_flags_reg
   logic [7:0] stack_q; // stacked flag image
   logic [7:0] opa_q; // operand a
   logic [7:0] opb_q; // operand b
   logic [7:0] res_q; // last result
   logic brk_q; // inside break handler
   logic brk_pend_q; // break waiting for instruction end
   logic [4:0] irq_idx_q; // request being served
   logic trap_q; // entry is a soft trap
   ccf_state_type st_q; // entry sequencer
   ccf_alu_type alu; // alu outputs
   ccf_op_type op; // decoded command

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic acc; // access phase
   logic wr; // write taken
   logic [11:0] off; // byte offset
   logic hit; // mapped address
   logic cmd_wr; // command write
   assign acc = psel && penable && pready && clk_en;
   assign wr = acc && pwrite;
   assign off = 12'(paddr);
   always_comb begin
      case (off)
         CCF_OFF_FLAGS, CCF_OFF_OPA, CCF_OFF_OPB, CCF_OFF_CMD,
         CCF_OFF_RES, CCF_OFF_IRQ, CCF_OFF_STAT, CCF_OFF_STACK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign cmd_wr = wr && hit && (off == CCF_OFF_CMD) && (st_q == CCF_ST_RUN);
   assign op = ccf_op_type'(pwdata[3:0]);

   // ----------------------------------------------------------------
   // alu instance
   // ----------------------------------------------------------------
   ccf_alu ccf_alu_inst (
      .a(opa_q),
      .b(opb_q),
      .c_in(flags_q[CCF_BIT_C]),
      .h_in(flags_q[CCF_BIT_H]),
      .op(op),
      .out(alu)
   );

   // ----------------------------------------------------------------
   // highest priority pending request
   // ----------------------------------------------------------------
   logic [4:0] pick; // chosen line
   logic any_req; // something pending
   always_comb begin
      pick = '0;
      any_req = 1'b0;
      // higher index is higher priority; last match wins
      for (int i = 0; i < CCF_NREQ; i++) begin
         if (irq_req[i]) begin
            pick = 5'(i);
            any_req = 1'b1;
         end
      end
   end
   logic take_irq; // accept maskable interrupt
   logic take_brk; // accept break entry
   assign take_irq = any_req && !flags_q[CCF_BIT_I];
   assign take_brk = brk_pend_q && !cmd_wr;
   logic is_ret; // return_from_handler write
   assign is_ret = cmd_wr && (op == CCF_OP_RTI);

   // ----------------------------------------------------------------
   // entry sequencer: push, then mask, then vector fetch
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= CCF_ST_RUN;
         trap_q <= 1'b0;
         irq_idx_q <= '0;
      end else if (clk_en) begin
         case (st_q)
            CCF_ST_RUN: begin
               if (cmd_wr && (op == CCF_OP_SWI)) begin
                  st_q <= CCF_ST_PUSH;
                  trap_q <= 1'b1;
               end else if (take_brk) begin
                  st_q <= CCF_ST_PUSH;
                  trap_q <= 1'b1;
               end else if (take_irq && !cmd_wr) begin
                  st_q <= CCF_ST_PUSH;
                  trap_q <= 1'b0;
                  irq_idx_q <= pick;
               end
            end
            CCF_ST_PUSH: st_q <= CCF_ST_MASK;
            CCF_ST_MASK: st_q <= CCF_ST_FETCH;
            CCF_ST_FETCH: st_q <= CCF_ST_RUN;
            default: st_q <= CCF_ST_RUN;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // stacked flag image; high index byte is not part of it
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_q <= CCF_FLAGS_RESET;
      end else if (clk_en) begin
         if (st_q == CCF_ST_PUSH) begin
            stack_q <= flags_q;
         end else if (wr && (off == CCF_OFF_STACK)) begin
            stack_q <= pwdata[7:0] | CCF_ONES_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // flag register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= CCF_FLAGS_RESET;
      end else if (clk_en) begin
         if (st_q == CCF_ST_MASK) begin
            flags_q[CCF_BIT_I] <= 1'b1;
         end else if (is_ret) begin
            flags_q <= stack_q | CCF_ONES_MASK;
         end else if (cmd_wr) begin
            case (op)
               CCF_OP_CLI: flags_q[CCF_BIT_I] <= 1'b0;
               CCF_OP_SEI: flags_q[CCF_BIT_I] <= 1'b1;
               CCF_OP_SWI: ;
               default: begin
                  flags_q[CCF_BIT_N] <= alu.res[7];
                  flags_q[CCF_BIT_Z] <= (alu.res == 8'h00);
                  if (alu.v_wr) begin
                     flags_q[CCF_BIT_V] <= alu.v;
                  end
                  if (alu.h_wr) begin
                     flags_q[CCF_BIT_H] <= alu.h;
                  end
                  if (alu.c_wr) begin
                     flags_q[CCF_BIT_C] <= alu.c;
                  end
               end
            endcase
         end else if (wr && (off == CCF_OFF_FLAGS)) begin
            // software writes result flags; mask bit is kept
            flags_q <= (pwdata[7:0] & ~(8'h01 << CCF_BIT_I))
               | (flags_q & (8'h01 << CCF_BIT_I)) | CCF_ONES_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // operands and result
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opa_q <= '0;
         opb_q <= '0;
         res_q <= '0;
      end else if (clk_en) begin
         if (wr && (off == CCF_OFF_OPA)) begin
            opa_q <= pwdata[7:0];
         end
         if (wr && (off == CCF_OFF_OPB)) begin
            opb_q <= pwdata[7:0];
         end
         if (cmd_wr && (op != CCF_OP_CLI) && (op != CCF_OP_SEI)
             && (op != CCF_OP_SWI) && (op != CCF_OP_RTI)) begin
            res_q <= alu.res;
         end
      end
   end

   // ----------------------------------------------------------------
   // break tracking
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_q <= 1'b0;
         brk_pend_q <= 1'b0;
      end else if (clk_en) begin
         // request waits for the current instruction to finish
         if (brk_en && brk_req && !brk_q && !brk_pend_q
             && (st_q == CCF_ST_RUN)) begin
            brk_pend_q <= 1'b1;
         end else if (take_brk && (st_q == CCF_ST_RUN)) begin
            brk_pend_q <= 1'b0;
            brk_q <= 1'b1;
         end else if (is_ret && brk_q && !brk_req) begin
            brk_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // vector output
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_addr <= '0;
         vec_fetch <= 1'b0;
      end else if (clk_en) begin
         vec_fetch <= (st_q == CCF_ST_MASK);
         if (st_q == CCF_ST_MASK) begin
            if (trap_q) begin
               vec_addr <= monitor_mode ? CCF_VEC_TRAP_MON
                  : CCF_VEC_TRAP;
            end else begin
               vec_addr <= 16'(CCF_VEC_BASE
                  + CCF_VEC_STEP * {11'h000, irq_idx_q});
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // apb answer, one wait free access
   // ----------------------------------------------------------------
   logic [31:0] rd; // read mux
   always_comb begin
      case (off)
         CCF_OFF_FLAGS: rd = {24'h0, flags_q | CCF_ONES_MASK};
         CCF_OFF_OPA: rd = {24'h0, opa_q};
         CCF_OFF_OPB: rd = {24'h0, opb_q};
         CCF_OFF_RES: rd = {24'h0, res_q};
         CCF_OFF_IRQ: rd = {15'h0, irq_req};
         CCF_OFF_STAT: rd = {24'h0, st_q, 2'b00, brk_pend_q, brk_q};
         CCF_OFF_STACK: rd = {24'h0, stack_q};
         default: rd = '0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata <= (psel && !penable && !pwrite) ? rd : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_out <= CCF_FLAGS_RESET;
         irq_mask_out <= 1'b1;
         in_break <= 1'b0;
      end else if (clk_en) begin
         flags_out <= flags_q | CCF_ONES_MASK;
         irq_mask_out <= flags_q[CCF_BIT_I];
         in_break <= brk_q;
      end
   end
endmodule // ccf_top
`default_nettype wire

// [tb/ccf_props.sv]
// checker for the condition flag block: flags, mask and vectors
// assumes it is bound to ccf_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module ccf_props #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [ccf_pkg::CCF_NREQ-1:0] irq_req,
   input wire logic brk_req,
   input wire logic brk_en,
   input wire logic monitor_mode,
   input wire logic [7:0] flags_out,
   input wire logic irq_mask_out,
   input wire logic [15:0] vec_addr,
   input wire logic vec_fetch,
   input wire logic in_break
);
   import ccf_pkg::*;
   // ---------------------------------------------------------------
   // helper logic
   // ---------------------------------------------------------------
   logic acc; // apb write completes at this edge
   logic clr_cmd; // clear or return command accepted
   logic [2:0] clr_win_q; // cycles left in which the mask may fall
   assign acc = psel && penable && pready && clk_en && pwrite;
   assign clr_cmd = acc && paddr == ADDR_W'(CCF_OFF_CMD)
      && (pwdata[3:0] == 4'h9 || pwdata[3:0] == 4'hC);
   // window opens on a clear or return, closes four cycles later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_win_q <= 3'h0;
      end else if (clr_cmd) begin
         clr_win_q <= 3'h4;
      end else if (clr_win_q != 3'h0) begin
         clr_win_q <= clr_win_q - 3'h1;
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable && clk_en;
   endsequence
   sequence s_trap;
      vec_fetch && (vec_addr == CCF_VEC_TRAP || vec_addr == CCF_VEC_TRAP_MON);
   endsequence
   sequence s_flags_wr;
      acc && paddr == ADDR_W'(CCF_OFF_FLAGS);
   endsequence
   a_ones_fixed: assert property (flags_out[6:5] == 2'h3)
      else $error("flag bits 6 and 5 not one");
   a_apb_answer: assert property (s_setup |=> pready)
      else $error("no answer after setup");
   a_flag_write: assert property (s_flags_wr |-> ##2
      ((flags_out & 8'h97) == ($past(pwdata[7:0], 2) & 8'h97))
      && $stable(flags_out[3]))
      else $error("flag write wrong");
   a_mask_fetch: assert property (vec_fetch |=> irq_mask_out)
      else $error("vector fetched with mask clear");
   a_mask_open: assert property (vec_fetch && vec_addr >= CCF_VEC_BASE
      && vec_addr < CCF_VEC_TRAP |-> $past(irq_mask_out, 2) == 1'b0)
      else $error("request taken while masked");
   a_mask_clear: assert property ($fell(irq_mask_out)
      |-> clr_win_q != 3'h0)
      else $error("mask cleared without clear or return");
   a_trap_mode: assert property (s_trap
      |-> vec_addr == (monitor_mode ? CCF_VEC_TRAP_MON : CCF_VEC_TRAP))
      else $error("trap vector does not match mode");
   a_break_exit: assert property ($fell(in_break)
      |-> !$past(brk_req, 2))
      else $error("break ended while request held");
endmodule // ccf_props
bind ccf_top ccf_props #(.ADDR_W(ADDR_W)) ccf_props_inst (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
   .brk_req(brk_req), .brk_en(brk_en), .monitor_mode(monitor_mode),
   .flags_out(flags_out), .irq_mask_out(irq_mask_out), .vec_addr(vec_addr),
   .vec_fetch(vec_fetch), .in_break(in_break));
`default_nettype wire

// [tb/ccf_top_test.sv]
// testbench for the condition flag block: apb access, alu, entry, break
// assumes the package, design and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module ccf_top_test;
   import ccf_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic pclk = 1'b0; // bus clock
   logic presetn = 1'b0; // reset, active low
   logic psel = 1'b0; // apb select
   logic penable = 1'b0; // apb access phase
   logic pwrite = 1'b0; // apb direction
   logic [11:0] paddr = 12'h000; // apb byte address
   logic [31:0] pwdata = 32'h0; // apb write data
   logic [CCF_NREQ-1:0] irq_req = '0; // maskable requests
   logic brk_req = 1'b0; // break request
   logic brk_en = 1'b0; // break module enable
   logic monitor_mode = 1'b0; // monitor trap vector select
   logic [31:0] prdata; // read data
   logic pready; // apb answer
   logic pslverr; // unmapped address
   logic [7:0] flags_out; // flag image
   logic irq_mask_out; // mask image
   logic [15:0] vec_addr; // vector address
   logic vec_fetch; // vector fetch pulse
   logic in_break; // inside break handler
   logic [31:0] rd_q; // last read data
   logic err_q; // last error response
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0; // watchdog count
   int vf_count = 0; // vector fetches seen
   int vf_seen; // snapshot of vf_count
   ccf_top #(.ADDR_W(12)) ccf_top_inst (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
      .brk_req(brk_req), .brk_en(brk_en), .monitor_mode(monitor_mode),
      .flags_out(flags_out), .irq_mask_out(irq_mask_out),
      .vec_addr(vec_addr), .vec_fetch(vec_fetch), .in_break(in_break));
   // ---------------------------------------------------------------
   // clock, watchdog and tasks
   // ---------------------------------------------------------------
   always #4 pclk = ~pclk;
   // counts fetches, cuts a hang short
   always @(posedge pclk) begin
      cycles++;
      if (vec_fetch === 1'b1) vf_count++;
      if (cycles == 5000) begin
         miscompares++;
         results();
      end
   end
   task results;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd_q, exp);
   endtask
   // preset flags, run one op, check result and flags (carry flag alone for bit test)
   task alu(input logic [7:0] op, a, b, pre, res, flg);
      wr(CCF_OFF_FLAGS, pre);
      wr(CCF_OFF_OPA, a);
      wr(CCF_OFF_OPB, b);
      wr(CCF_OFF_CMD, op);
      if (op != 8'h0D) rdc("result", CCF_OFF_RES, {24'h0, res});
      apb(1'b0, CCF_OFF_FLAGS, 32'h0);
      chk("flags", rd_q & (op == 8'h0D ? 32'h1 : 32'hFF), {24'h0, flg});
   endtask
   // waits for a vector fetch, compares its address
   task wait_vec(input logic [15:0] exp);
      int n;
      n = 0;
      while (vec_fetch !== 1'b1 && n < 30) begin
         @(posedge pclk);
         n++;
      end
      chk("vector", {16'h0, vec_addr}, {16'h0, exp});
      @(posedge pclk);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk("flags_out", {24'h0, flags_out}, 32'h68);
      chk("mask", {31'h0, irq_mask_out}, 32'h1);
      rdc("status", CCF_OFF_STAT, 32'h10);
      rdc("hole", 12'h020, 32'h0);
      chk("slverr", {31'h0, err_q}, 32'h1);
      wr(CCF_OFF_FLAGS, 8'h00);
      rdc("flags", CCF_OFF_FLAGS, 32'h68);
      wr(CCF_OFF_FLAGS, 8'hFF);
      rdc("flags", CCF_OFF_FLAGS, 32'hFF);
      alu(8'h00, 8'h7F, 8'h01, 8'h68, 8'h80, 8'hFC);
      alu(8'h00, 8'hFF, 8'h01, 8'h68, 8'h00, 8'h7B);
      alu(8'h01, 8'h08, 8'h07, 8'h69, 8'h10, 8'h78);
      alu(8'h02, 8'h00, 8'h01, 8'h68, 8'hFF, 8'h6D);
      alu(8'h02, 8'h80, 8'h01, 8'h68, 8'h7F, 8'hE8);
      alu(8'h03, 8'h05, 8'h05, 8'h69, 8'hFF, 8'h6D);
      alu(8'h04, 8'hF0, 8'h0F, 8'hE9, 8'h00, 8'h6B);
      alu(8'h05, 8'h80, 8'h00, 8'hE8, 8'h80, 8'h6C);
      alu(8'h06, 8'hC0, 8'h00, 8'h68, 8'h80, 8'h6D);
      alu(8'h07, 8'h01, 8'h00, 8'h69, 8'h80, 8'h6D);
      alu(8'h08, 8'h0A, 8'h00, 8'h68, 8'h10, 8'h68);
      alu(8'h08, 8'h00, 8'h00, 8'h78, 8'h06, 8'h78);
      alu(8'h08, 8'h00, 8'h00, 8'h69, 8'h60, 8'h69);
      alu(8'h0D, 8'h04, 8'h02, 8'h68, 8'h00, 8'h01);
      wr(CCF_OFF_CMD, 8'h0A);
      vf_seen = vf_count;
      irq_req <= 17'h00204;
      repeat (10) @(posedge pclk);
      chk("masked", vf_count, vf_seen);
      wr(CCF_OFF_CMD, 8'h09);
      wait_vec(16'hFFEA);
      irq_req <= '0;
      chk("mask", {31'h0, irq_mask_out}, 32'h1);
      apb(1'b0, CCF_OFF_STACK, 32'h0);
      chk("stacked", rd_q & 32'h8, 32'h0);
      wr(CCF_OFF_CMD, 8'h0C);
      repeat (2) @(posedge pclk);
      chk("mask", {31'h0, irq_mask_out}, 32'h0);
      wr(CCF_OFF_CMD, 8'h0B);
      wait_vec(CCF_VEC_TRAP);
      wr(CCF_OFF_CMD, 8'h0C);
      monitor_mode <= 1'b1;
      wr(CCF_OFF_CMD, 8'h0B);
      wait_vec(CCF_VEC_TRAP_MON);
      wr(CCF_OFF_CMD, 8'h0C);
      vf_seen = vf_count;
      brk_req <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("no break", vf_count, vf_seen);
      brk_en <= 1'b1;
      wait_vec(CCF_VEC_TRAP_MON);
      wr(CCF_OFF_CMD, 8'h0C);
      repeat (3) @(posedge pclk);
      chk("held", {31'h0, in_break}, 32'h1);
      brk_req <= 1'b0;
      repeat (10) @(posedge pclk);
      wr(CCF_OFF_CMD, 8'h0C);
      repeat (3) @(posedge pclk);
      chk("left", {31'h0, in_break}, 32'h0);
      rdc("status", CCF_OFF_STAT, 32'h10);
      wr(CCF_OFF_CMD, 8'h09);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("mask", {31'h0, irq_mask_out}, 32'h1);
      chk("flags_out", {24'h0, flags_out}, 32'h68);
      results();
   end
endmodule // ccf_top_test
`default_nettype wire
